// File: hdl/bsp_phy.sv
// Symbol encoder, decoder and modem management of the broadband symbol path
`timescale 1ns/1ps
module bsp_phy (
	// Core clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// Request channel from the protocol handler
	input wire logic REQUEST_CLK,
	input wire bsp_pkg::bsp_req_t REQ,
	// Indication channel to the protocol handler
	output logic [2:0] RX_SYMBOL,
	output logic RX_SYMBOL_STROBE,
	output logic MGMT_NAK,
	// RF transmitter
	input wire logic TX_CODE_CLK,
	output logic TX_CODE_BIT_A,
	output logic TX_CODE_BIT_B,
	output logic POWER_STAGE_OFF,
	// RF receiver
	input wire logic RECOVERED_CLK,
	input wire bsp_pkg::bsp_amp_t RX_AMP,
	output logic GAIN_FREEZE,
	output logic RX_SILENCE_ERR,
	// Modem status
	input wire bsp_pkg::bsp_modem_t MODEM,
	output logic [1:0] MODE_STATE,
	// Bidirectional reset pin
	input wire logic PHY_RESET_I,
	output logic PHY_RESET_O,
	output logic PHY_RESET_OE
);
	import bsp_pkg::*;

	// Whole state of the block
	typedef struct packed {
		logic prev_req_clk;
		logic prev_rec_clk;
		logic prev_tx_clk;
		logic [1:0] tx_pend;
		logic [1:0] tx_code;
		logic pad_phase;
		logic tx_en;
		logic pwr_off;
		bsp_mode_t mode;
		logic nak;
		logic [2:0] rx_sym;
		logic rx_strobe;
		logic rx_silence_err;
		logic gain_freeze;
		logic [15:0] hist;
		logic [1:0] last_amp;
		logic [4:0] run_cnt;
		logic rst_drive;
		logic [7:0] rst_cnt;
	} bsp_phy_st_t;

	bsp_phy_st_t st_ff;
	bsp_phy_st_t nxt_st;

	logic [SY_WIDTH-1:0] sy_in;
	logic [SY_WIDTH-1:0] sy;
	logic req_fall;
	logic rec_fall;
	logic tx_rise;
	logic int_rst;
	logic [2:0] req_sym;
	logic req_mode_n;
	logic [1:0] amp;
	logic alarm;
	logic fault;
	logic energy;
	logic [15:0] new_hist;
	logic [4:0] run_inc;
	logic [1:0] enc;

	// Marker match over eight received symbols, oldest at position 7
	function automatic logic marker_match(input logic [15:0] h, input logic closing);
		logic ok;
		ok = h[15] & h[13] & h[9] & h[7];
		ok = ok & ~h[11] & (h[10] == closing) & ~h[5] & (h[4] == closing);
		if (!closing) begin
			ok = ok & ~h[3] & ~h[2] & ~h[1] & ~h[0];
		end
		return ok;
	endfunction : marker_match

	// Translate a data-mode request into a transmit code
	function automatic logic [1:0] encode_req(input logic [2:0] s, input logic pad);
		logic [1:0] c;
		c = TXC_SILENCE;
		if (s == REQ_ZERO) begin
			c = TXC_ZERO;
		end else if (s == REQ_ONE) begin
			c = TXC_ONE;
		end else if (s[2:1] == REQ_NONDATA_HI) begin
			c = TXC_NONDATA;
		end else if (s[2:1] == REQ_PAD_HI) begin
			c = pad ? TXC_ONE : TXC_ZERO;
		end
		return c;
	endfunction : encode_req

	// All pin inputs except RST, link clocks included, pass two flops
	assign sy_in = {PHY_RESET_I, MODEM.rx_energy, MODEM.modem_fault, MODEM.overlong_alarm,
		TX_CODE_CLK, RX_AMP.bit_a, RX_AMP.bit_b, RECOVERED_CLK, REQ.mgmt_mode_n, REQ.symbol, REQUEST_CLK};

	bsp_sync #(
		.WIDTH(SY_WIDTH)
	) u_sync (
		.clk(CORE_CLK),
		.rst(RST),
		.async_in(sy_in),
		.sync_out(sy)
	);

	// Named views of the synchronised inputs
	assign req_sym = sy[SY_REQ_LO +: 3];
	assign req_mode_n = sy[SY_REQ_LO + 3];
	assign amp = sy[SY_AMP_LO +: 2];
	assign alarm = sy[SY_ALARM];
	assign fault = sy[SY_FAULT];
	assign energy = sy[SY_ENERGY];

	// Edges of the sampled link clocks
	assign req_fall = st_ff.prev_req_clk & ~sy[SY_REQ_CLK];
	assign rec_fall = st_ff.prev_rec_clk & ~sy[SY_REC_CLK];
	assign tx_rise = ~st_ff.prev_tx_clk & sy[SY_TX_CLK];

	// Pin reset counts only while we are not the driver
	assign int_rst = RST | (sy[SY_RESET] & ~st_ff.rst_drive);

	// Receive history shift and same-input run count
	assign new_hist = {st_ff.hist[13:0], amp[1], amp[1] ? amp[0] : (amp == AMP_ONE)};
	assign run_inc = st_ff.run_cnt + 5'h1;
	assign enc = encode_req(req_sym, st_ff.pad_phase);

	// Next-state logic
	always_comb begin
		nxt_st = st_ff;
		nxt_st.prev_req_clk = sy[SY_REQ_CLK];
		nxt_st.prev_rec_clk = sy[SY_REC_CLK];
		nxt_st.prev_tx_clk = sy[SY_TX_CLK];
		nxt_st.rx_strobe = 1'b0;

		// Operating mode from alarm, fault and mode line
		if (alarm) begin
			nxt_st.mode = BSP_TX_BLOCKED;
		end else if (fault) begin
			nxt_st.mode = BSP_FAULTED;
		end else if (req_mode_n) begin
			nxt_st.mode = BSP_ONLINE;
		end else begin
			nxt_st.mode = BSP_OFFLINE;
		end

		// Request channel sampled mid bit, away from the handler's edge
		if (req_fall) begin
			if (req_mode_n) begin
				nxt_st.tx_pend = enc;
				if (req_sym[2:1] == REQ_PAD_HI) begin
					nxt_st.pad_phase = ~st_ff.pad_phase;
				end else begin
					nxt_st.pad_phase = 1'b0;
				end
			end else begin
				nxt_st.tx_pend = TXC_SILENCE;
				nxt_st.nak = 1'b0;
				if (req_sym == CMD_RESET) begin
					nxt_st.rst_drive = 1'b1;
					nxt_st.rst_cnt = 8'(RESET_PULSE_CYC);
					nxt_st.tx_en = 1'b0;
				end else if (req_sym == CMD_TX_ENABLE) begin
					nxt_st.tx_en = 1'b1;
				end else if (req_sym == CMD_LOOP_OFF || req_sym[2:1] == CMD_SERIAL_HI) begin
					nxt_st.nak = 1'b0;
				end else begin
					nxt_st.nak = 1'b1;
				end
			end
		end

		// Commanded reset pulse on the pin
		if (st_ff.rst_drive) begin
			if (st_ff.rst_cnt == 8'h00) begin
				nxt_st.rst_drive = 1'b0;
			end else begin
				nxt_st.rst_cnt = st_ff.rst_cnt - 8'h01;
			end
		end

		// Power stage gate: on-line, enabled and no alarm
		nxt_st.pwr_off = alarm | ~st_ff.tx_en | (st_ff.mode != BSP_ONLINE);

		// Stage off or alarm silences at once, otherwise codes move on the code clock rise
		if (st_ff.pwr_off || alarm) begin
			nxt_st.tx_code = TXC_SILENCE;
		end else if (tx_rise) begin
			nxt_st.tx_code = st_ff.tx_pend;
		end

		// Receive decoding on the recovered clock falling edge
		if (rec_fall) begin
			nxt_st.rx_strobe = 1'b1;
			nxt_st.hist = new_hist;
			nxt_st.last_amp = amp;
			if (!energy) begin
				nxt_st.rx_sym = IND_SILENCE;
				nxt_st.rx_silence_err = 1'b1;
			end else if (amp == AMP_ZERO) begin
				nxt_st.rx_sym = IND_ZERO;
			end else if (amp == AMP_ONE) begin
				nxt_st.rx_sym = IND_ONE;
			end else begin
				nxt_st.rx_sym = {IND_NONDATA_HI, amp[0]};
			end
			if (amp == st_ff.last_amp) begin
				nxt_st.run_cnt = (st_ff.run_cnt == 5'(SAME_RUN_LIMIT)) ? st_ff.run_cnt : run_inc;
			end else begin
				nxt_st.run_cnt = 5'h1;
			end
			// Gain freeze from opening marker to closing marker or long run
			if (marker_match(new_hist, 1'b0)) begin
				nxt_st.gain_freeze = 1'b1;
			end else if (marker_match(new_hist, 1'b1)) begin
				nxt_st.gain_freeze = 1'b0;
			end else if (nxt_st.run_cnt == 5'(SAME_RUN_LIMIT)) begin
				nxt_st.gain_freeze = 1'b0;
			end
		end else if (energy) begin
			nxt_st.rx_silence_err = 1'b0;
		end
		if (!energy) begin
			nxt_st.gain_freeze = 1'b0;
		end
	end

	// Register the state
	always_ff @(posedge CORE_CLK) begin
		if (int_rst) begin
			st_ff <= '{
				prev_req_clk: 1'b0,
				prev_rec_clk: 1'b0,
				prev_tx_clk: 1'b1, // No false rise when the code clock is high at release of a pin reset
				tx_pend: TXC_SILENCE,
				tx_code: TXC_SILENCE,
				pad_phase: 1'b0,
				tx_en: 1'b0,
				pwr_off: 1'b1,
				mode: BSP_OFFLINE,
				nak: 1'b0,
				rx_sym: IND_SILENCE,
				rx_strobe: 1'b0,
				rx_silence_err: 1'b0,
				gain_freeze: 1'b0,
				hist: 16'h0000,
				last_amp: AMP_ZERO,
				run_cnt: 5'h00,
				rst_drive: 1'b0,
				rst_cnt: 8'h00
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register
	assign TX_CODE_BIT_A = st_ff.tx_code[1];
	assign TX_CODE_BIT_B = st_ff.tx_code[0];
	assign POWER_STAGE_OFF = st_ff.pwr_off;
	assign RX_SYMBOL = st_ff.rx_sym;
	assign RX_SYMBOL_STROBE = st_ff.rx_strobe;
	assign MGMT_NAK = st_ff.nak;
	assign GAIN_FREEZE = st_ff.gain_freeze;
	assign RX_SILENCE_ERR = st_ff.rx_silence_err;
	assign MODE_STATE = st_ff.mode;
	assign PHY_RESET_O = st_ff.rst_drive;
	assign PHY_RESET_OE = st_ff.rst_drive;

endmodule : bsp_phy

// File: hdl/bsp_pkg.sv
// Constants, codes, states and carrier types of the broadband symbol path
// Functional notes
// - Pad-idle sent as alternating one/zero pattern
// - Received training reported as plain ones, zeros
// - Opening marker is N N 0 N N 0 0 0
// - Closing marker N N 1 N N 1 plus two status bits
// - Silence on receive input flags an error
// - Receive decoding inverts the transmit encoding
// - Mode follows mode line, alarm and fault
// - Reset pin is input unless commanded to drive
// - Overlong-transmit alarm stops all transmission
// - Power-stage-off output disables the RF amplifier
// - Gain-freeze output holds the receiver gain
// - Code outputs change on code clock rising edge
// - Amplitude inputs sampled on recovered clock falling edge
// - Mode line high is on-line, low is management
package bsp_pkg;

	// Core clock period
	localparam int CORE_CLK_PERIOD_NS = 8;

	// Length of the commanded reset pulse on the reset pin
	localparam int RESET_PULSE_NS = 800;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;

	// Run of identical received inputs that releases gain freeze
	localparam int SAME_RUN_LIMIT = 24;

	// Request symbol codes in on-line mode (bit 0 is don't care for the last three)
	localparam logic [2:0] REQ_ZERO = 3'h0;
	localparam logic [2:0] REQ_ONE = 3'h1;
	localparam logic [1:0] REQ_NONDATA_HI = 2'h2;
	localparam logic [1:0] REQ_PAD_HI = 2'h1;
	localparam logic [1:0] REQ_SILENCE_HI = 2'h3;

	// Management commands on the request lines
	localparam logic [2:0] CMD_RESET = 3'h7;
	localparam logic [2:0] CMD_LOOP_OFF = 3'h5;
	localparam logic [2:0] CMD_TX_ENABLE = 3'h3;
	localparam logic [1:0] CMD_SERIAL_HI = 2'h0;

	// Transmit code outputs with the precoder off
	localparam logic [1:0] TXC_ZERO = 2'h0;
	localparam logic [1:0] TXC_ONE = 2'h1;
	localparam logic [1:0] TXC_NONDATA = 2'h2;
	localparam logic [1:0] TXC_SILENCE = 2'h3;

	// Received amplitude codes
	localparam logic [1:0] AMP_ZERO = 2'h0;
	localparam logic [1:0] AMP_ONE = 2'h1;

	// Symbols handed to the protocol handler, same layout as requests
	localparam logic [2:0] IND_ZERO = 3'h0;
	localparam logic [2:0] IND_ONE = 3'h1;
	localparam logic [2:0] IND_SILENCE = 3'h6;
	localparam logic [1:0] IND_NONDATA_HI = 2'h2;

	// Synchroniser bit positions
	localparam int SY_REQ_CLK = 0;
	localparam int SY_REQ_LO = 1;
	localparam int SY_REC_CLK = 5;
	localparam int SY_AMP_LO = 6;
	localparam int SY_TX_CLK = 8;
	localparam int SY_ALARM = 9;
	localparam int SY_FAULT = 10;
	localparam int SY_ENERGY = 11;
	localparam int SY_RESET = 12;
	localparam int SY_WIDTH = 13;

	// Operating mode, Gray coded along offline, online, blocked
	typedef enum logic [1:0] {
		BSP_OFFLINE = 2'h0,
		BSP_ONLINE = 2'h1,
		BSP_TX_BLOCKED = 2'h3,
		BSP_FAULTED = 2'h2
	} bsp_mode_t;

	// Request channel: mode line and three symbol lines
	typedef struct packed {
		logic mgmt_mode_n;
		logic [2:0] symbol;
	} bsp_req_t;

	// Received amplitude pair
	typedef struct packed {
		logic bit_a;
		logic bit_b;
	} bsp_amp_t;

	// Modem status inputs
	typedef struct packed {
		logic overlong_alarm;
		logic modem_fault;
		logic rx_energy;
	} bsp_modem_t;

endpackage : bsp_pkg

// File: hdl/bsp_sync.sv
// Two-flop synchroniser bank for inputs from outside the core clock domain
`timescale 1ns/1ps
module bsp_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Asynchronous inputs and their synchronised copies
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// Both stages of every bit
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} bsp_sync_st_t;

	bsp_sync_st_t st_ff;
	bsp_sync_st_t nxt_st;

	// First stage feeds only the second
	always_comb begin
		nxt_st = st_ff;
		nxt_st.meta = async_in;
		nxt_st.stable = st_ff.meta;
	end

	// Register both stages
	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sync_out = st_ff.stable;

endmodule : bsp_sync

// File: sim/bsp_phy_assertions.sv
// Concurrent checks on the ports of the broadband symbol path
`timescale 1ns/1ps
module bsp_phy_assertions (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// Transmit side
	input wire logic TX_CODE_CLK,
	input wire logic TX_CODE_BIT_A,
	input wire logic TX_CODE_BIT_B,
	input wire logic POWER_STAGE_OFF,
	// Receive side
	input wire logic [2:0] RX_SYMBOL,
	input wire logic RX_SYMBOL_STROBE,
	input wire logic GAIN_FREEZE,
	// Modem and reset pin
	input wire bsp_pkg::bsp_modem_t MODEM,
	input wire logic [1:0] MODE_STATE,
	input wire logic PHY_RESET_OE
);
	import bsp_pkg::*;
	logic [7:0] drive_len_ff;
	logic [7:0] nxt_drive_len;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// Cycles the reset pin has been driven so far
	always_comb begin
		nxt_drive_len = PHY_RESET_OE ? drive_len_ff + 8'h01 : 8'h00;
	end
	always_ff @(posedge CORE_CLK) begin
		drive_len_ff <= RST ? 8'h00 : nxt_drive_len;
	end
	// Port relations
	blocked_pso_a: assert property (MODE_STATE == BSP_TX_BLOCKED |-> POWER_STAGE_OFF)
		else $error("power stage on while blocked");
	off_silent_a: assert property (POWER_STAGE_OFF [*2] |-> {TX_CODE_BIT_A, TX_CODE_BIT_B} == TXC_SILENCE)
		else $error("code not silence with stage off");
	alarm_block_a: assert property (MODEM.overlong_alarm [*5] |-> MODE_STATE == BSP_TX_BLOCKED)
		else $error("alarm did not block");
	sync_lag_a: assert property ($rose(MODEM.overlong_alarm) && MODE_STATE != BSP_TX_BLOCKED
		|=> MODE_STATE != BSP_TX_BLOCKED) else $error("alarm not synchronised");
	strobe_pulse_a: assert property (RX_SYMBOL_STROBE |=> !RX_SYMBOL_STROBE)
		else $error("strobe longer than one cycle");
	sym_strobe_a: assert property ($changed(RX_SYMBOL) && RX_SYMBOL != IND_SILENCE |-> RX_SYMBOL_STROBE)
		else $error("symbol changed without strobe");
	drive_len_a: assert property ($fell(PHY_RESET_OE) |-> drive_len_ff == RESET_PULSE_CYC + 1)
		else $error("reset drive length wrong");
	code_edge_a: assert property ($changed({TX_CODE_BIT_A, TX_CODE_BIT_B}) && MODE_STATE == BSP_ONLINE
		&& !POWER_STAGE_OFF |-> $past(TX_CODE_CLK, 2)) else $error("code changed off code clock");
	freeze_drop_a: assert property (!MODEM.rx_energy [*5] |-> !GAIN_FREEZE)
		else $error("gain frozen without energy");
	// Main scenarios reached
	cover property ($rose(GAIN_FREEZE));
	cover property ($fell(PHY_RESET_OE));
	cover property (MODE_STATE == BSP_FAULTED);
endmodule : bsp_phy_assertions

// File: sim/bsp_partner.sv
// Protocol handler and modem model on the link clock
`timescale 1ns/1ps
module bsp_partner (
	// Symbols chosen by the bench
	input wire bsp_pkg::bsp_req_t req_in,
	input wire bsp_pkg::bsp_amp_t amp_in,
	// Link lines
	output logic link_clk,
	output bsp_pkg::bsp_req_t req,
	output bsp_pkg::bsp_amp_t amp
);
	import bsp_pkg::*;
	// Headend clock runs at all times
	initial begin
		link_clk = 1'b0;
		req = 4'h0;
		amp = 2'h0;
	end
	always #80 link_clk = ~link_clk;
	// One symbol per bit time, launched on the rising edge
	always @(posedge link_clk) begin
		req <= req_in;
		amp <= amp_in;
	end
endmodule : bsp_partner

// File: sim/bsp_phy_tb_top.sv
// Self-checking testbench of the broadband symbol path
`timescale 1ns/1ps
module bsp_phy_tb_top;
	import bsp_pkg::*;
	// Stimulus, link lines and observed outputs
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ext_rst = 1'b0;
	bsp_req_t req_in = 4'h0;
	bsp_amp_t amp_in = 2'h0;
	bsp_modem_t modem = 3'h1;
	bsp_req_t req;
	bsp_amp_t amp;
	logic lclk, stb, nak, ca, cb, pso, frz, serr, rso, rsoe;
	logic [2:0] sym;
	logic [1:0] mode;
	int error_cnt = 0;
	int compares = 0;
	int w;
	always #4 clk = ~clk;
	// Handler and modem model
	bsp_partner peer_u (.req_in(req_in), .amp_in(amp_in), .link_clk(lclk), .req(req), .amp(amp));
	// Device, reset pin level from both drivers
	bsp_phy dut_u (.CORE_CLK(clk), .RST(rst), .REQUEST_CLK(lclk), .REQ(req), .RX_SYMBOL(sym),
		.RX_SYMBOL_STROBE(stb), .MGMT_NAK(nak), .TX_CODE_CLK(lclk), .TX_CODE_BIT_A(ca),
		.TX_CODE_BIT_B(cb), .POWER_STAGE_OFF(pso), .RECOVERED_CLK(lclk), .RX_AMP(amp),
		.GAIN_FREEZE(frz), .RX_SILENCE_ERR(serr), .MODEM(modem), .MODE_STATE(mode),
		.PHY_RESET_I(ext_rst | (rsoe & rso)), .PHY_RESET_O(rso), .PHY_RESET_OE(rsoe));
	// Compare and count
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	// Wait whole bit times
	task automatic bits(input int n);
		repeat (n) @(negedge lclk);
		@(posedge clk);
	endtask : bits
	task automatic put(input bsp_req_t r);
		req_in <= r;
		bits(2);
	endtask : put
	// Stream symbols out or in, checking each two bit times later
	task automatic run(input string s, input bit rx);
		byte c;
		bit ph;
		logic [2:0] r;
		logic [1:0] a;
		logic [2:0] x;
		logic [2:0] e[$];
		ph = 1'b0;
		for (int k = 0; k < s.len() + 2; k++) begin
			@(negedge lclk);
			if (k >= 2) begin
				chk(rx ? sym : {ca, cb}, e.pop_front());
			end
			c = k < s.len() ? s[k] : (rx ? "0" : "S");
			case (c)
				"0": begin r = REQ_ZERO; a = AMP_ZERO; x = rx ? IND_ZERO : TXC_ZERO; end
				"1": begin r = REQ_ONE; a = AMP_ONE; x = rx ? IND_ONE : TXC_ONE; end
				"N": begin r = {REQ_NONDATA_HI, 1'b0}; a = 2'h2; x = rx ? {IND_NONDATA_HI, 1'b0} : TXC_NONDATA; end
				"M": begin r = 3'h0; a = 2'h3; x = {IND_NONDATA_HI, 1'b1}; end
				"P": begin r = {REQ_PAD_HI, 1'b0}; a = 2'h0; x = {2'h0, ph}; end
				default: begin r = {REQ_SILENCE_HI, 1'b0}; a = 2'h0; x = TXC_SILENCE; end
			endcase
			ph = c == "P" ? ~ph : 1'b0;
			e.push_back(x);
			@(posedge clk);
			if (rx) begin
				amp_in <= a;
			end else begin
				req_in <= {1'b1, r};
			end
		end
	endtask : run
	// Hang guard
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		bits(1);
		chk({ca, cb}, TXC_SILENCE);
		chk({pso, rsoe, mode}, {1'b1, 1'b0, BSP_OFFLINE});
		chk(sym, IND_SILENCE);
		put({1'b0, 3'h2});
		chk(nak, 1'b1);
		put({1'b0, CMD_LOOP_OFF});
		chk(nak, 1'b0);
		put({1'b0, CMD_TX_ENABLE});
		put({1'b1, REQ_SILENCE_HI, 1'b0});
		chk(mode, BSP_ONLINE);
		$display("management done");
		run("PPPPPPPPNN0NN00001101001NN1NN110SS", 1'b0);
		$display("transmit frame done");
		ext_rst <= 1'b1;
		bits(1);
		ext_rst <= 1'b0;
		bits(2);
		chk({pso, ca, cb}, 3'h7);
		modem <= 3'h5;
		bits(1);
		chk({mode, pso, ca, cb}, {BSP_TX_BLOCKED, 3'h7});
		modem <= 3'h3;
		bits(1);
		chk(mode, BSP_FAULTED);
		modem <= 3'h1;
		bits(1);
		chk(mode, BSP_ONLINE);
		$display("modem status done");
		run("01010101NM0NN000", 1'b1);
		chk(frz, 1'b1);
		run("NN1NN110", 1'b1);
		chk(frz, 1'b0);
		modem <= 3'h0;
		bits(2);
		chk({serr, sym}, {1'b1, IND_SILENCE});
		modem <= 3'h1;
		$display("receive done");
		req_in <= {1'b0, CMD_RESET};
		@(posedge lclk);
		@(posedge clk);
		req_in <= 4'h0;
		for (w = 0; w < 400 && rsoe !== 1'b1; w++) @(posedge clk);
		for (w = 0; w < 400 && rsoe === 1'b1; w++) @(posedge clk);
		chk(w[7:0], RESET_PULSE_CYC + 1);
		$display("reset command done");
		tally_and_finish();
	end
endmodule : bsp_phy_tb_top
bind bsp_phy bsp_phy_assertions chk_u (.CORE_CLK(CORE_CLK), .RST(RST), .TX_CODE_CLK(TX_CODE_CLK),
	.TX_CODE_BIT_A(TX_CODE_BIT_A), .TX_CODE_BIT_B(TX_CODE_BIT_B), .POWER_STAGE_OFF(POWER_STAGE_OFF),
	.RX_SYMBOL(RX_SYMBOL), .RX_SYMBOL_STROBE(RX_SYMBOL_STROBE), .GAIN_FREEZE(GAIN_FREEZE),
	.MODEM(MODEM), .MODE_STATE(MODE_STATE), .PHY_RESET_OE(PHY_RESET_OE));
